/* src/lcj_pkg.sv */
package lcj_pkg;

	// register bus
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int VAL_W  = 20;
	localparam int RDG_W  = 21;

	// word offsets
	localparam logic [3:0] ADR_CTRL   = 4'h0;
	localparam logic [3:0] ADR_R_BASE = 4'h1;
	localparam logic [3:0] ADR_V_BASE = 4'h5;
	localparam logic [3:0] ADR_MCFG   = 4'h9;
	localparam logic [3:0] ADR_CMD    = 4'hA;
	localparam logic [3:0] ADR_STATUS = 4'hB;
	localparam logic [3:0] ADR_R_REL  = 4'hC;
	localparam logic [3:0] ADR_V_REL  = 4'hD;

	// per-channel slot within a channel block
	localparam logic [1:0] SLOT_UPPER = 2'h0;
	localparam logic [1:0] SLOT_LOWER = 2'h1;
	localparam logic [1:0] SLOT_REF   = 2'h2;
	localparam logic [1:0] SLOT_TOL   = 2'h3;

	// control register fields
	localparam int CTRL_COMP_EN  = 0;
	localparam int CTRL_METHOD   = 1;
	localparam int CTRL_MANUAL   = 2;
	localparam int CTRL_ABS_EN   = 3;
	localparam int CTRL_BEEP_LSB = 4;
	localparam int CTRL_BEEP_MSB = 6;
	localparam int CTRL_CURSOR   = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// command register fields
	localparam int CMD_LOAD_RDG  = 0;
	localparam int CMD_LOAD_STAT = 1;
	localparam int CMD_LOWER     = 2;
	localparam int CMD_CHAN      = 3;

	// measurement configuration, bit 0 is auto-ranging
	localparam int MCFG_W        = 16;
	localparam int MCFG_AUTORNG  = 0;
	localparam logic [15:0] MCFG_RESET = 16'h0001;

	// limits in counts, tolerance and relative in 0.001 %
	localparam logic [19:0] R_MAX   = 20'h1869F;
	localparam logic [19:0] V_MAX   = 20'hF423F;
	localparam logic [19:0] TOL_MAX = 20'h1869F;
	localparam logic [19:0] REL_LIM = 20'h1869F;
	localparam logic [39:0] PCT     = 40'h00000186A0;
	localparam logic [21:0] SIGMA_K = 22'h000003;

	// timing
	localparam int CLK_NS  = 25;
	localparam int BEEP_NS = 100000000;
	localparam int BEEP_CYC = (BEEP_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		JDG_NONE = 2'b00,
		JDG_LO   = 2'b01,
		JDG_IN   = 2'b11,
		JDG_HI   = 2'b10
	} lcj_judge_t;

	typedef enum logic [2:0] {
		BM_OFF                    = 3'h0,
		BM_REPEAT_ON_OUT_OF_BAND  = 3'h1,
		BM_STEADY_ON_PASS         = 3'h3,
		BM_STEADY_PASS_REPEAT_OUT = 3'h2,
		BM_SINGLE_PASS_REPEAT_OUT = 3'h6
	} lcj_beep_t;

	typedef struct packed {
		logic                    done;
		logic signed [RDG_W-1:0] value;
		logic                    fault;
		logic                    overflow_high;
		logic                    overflow_low;
	} lcj_reading_t;

	typedef struct packed {
		logic [VAL_W-1:0] mean;
		logic [VAL_W-1:0] sigma;
	} lcj_stat_t;

endpackage : lcj_pkg

/* src/lcj_judge.sv */
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// Operation
// - thresholds kept as raw display counts
// - settings locked while comparator enabled
// - five beeper modes including single beep
// - beeper silent when off or unjudged
// - auto always outputs, manual needs gate except for the beeper
// - direct limits or reference plus tolerance
// - limits from reference times hundred plus/minus
// - relative value in percent of reference
// - relative beyond 99.999 percent overflows
// - load reading unless faulty or overflowed
// - statistics load mean plus/minus three sigma
// - statistics load ignored without result
// - loads only on non-numeric cursor
// - values limited, negatives never accepted
// - statistics values clamped to range
// - optional magnitude judgment for voltage
// - measurement settings locked while enabled
// - enabling comparator disables auto-ranging
// - channels judged independently, both shown
// - Hi above, Lo below, IN between
// - fault none, overflows give Hi/Lo
// - pass only when both channels IN
module lcj_judge #(
	parameter int BEEP_CYCLES = lcj_pkg::BEEP_CYC
) (
	// clock and reset
	input  wire logic                           mclk_in,
	input  wire logic                           rstn_in,
	// register port
	input  wire logic [lcj_pkg::ADDR_W-1:0]     reg_addr_in,
	input  wire logic [lcj_pkg::DATA_W-1:0]     reg_wdata_in,
	input  wire logic                           reg_wr_in,
	input  wire logic                           reg_rd_in,
	output logic      [lcj_pkg::DATA_W-1:0]     reg_rdata_out,
	// measurement engine
	input  wire lcj_pkg::lcj_reading_t          res_rdg_in,
	input  wire lcj_pkg::lcj_reading_t          volt_rdg_in,
	input  wire lcj_pkg::lcj_stat_t             res_stat_in,
	input  wire lcj_pkg::lcj_stat_t             volt_stat_in,
	input  wire logic                           stat_valid_in,
	// external control
	input  wire logic                           hand_judge_gate_in,
	// results
	output lcj_pkg::lcj_judge_t                 res_judge_out,
	output lcj_pkg::lcj_judge_t                 volt_judge_out,
	output logic                                pass_out,
	output logic                                fail_out,
	output logic                                beep_out,
	output logic      [lcj_pkg::MCFG_W-1:0]     meas_cfg_out
);
	import lcj_pkg::*;

	logic        [7:0]        ctrl_r;
	logic        [MCFG_W-1:0] mcfg_r;
	logic        [VAL_W-1:0]  up_r   [2];
	logic        [VAL_W-1:0]  lo_r   [2];
	logic        [VAL_W-1:0]  ref_r  [2];
	logic        [VAL_W-1:0]  tol_r  [2];
	logic        [VAL_W-1:0]  last_r [2];
	logic                     last_ok_r [2];
	lcj_judge_t               judge_r [2];
	logic signed [RDG_W-1:0]  rel_r  [2];
	logic                     relh_r [2];
	logic                     rell_r [2];
	logic        [DATA_W-1:0] rdata_r;
	lcj_judge_t               res_out_r;
	lcj_judge_t               volt_out_r;
	logic                     pass_r;
	logic                     fail_r;
	logic                     beep_r;
	logic                     tone_r;
	logic        [31:0]       tone_cnt_r;
	logic        [31:0]       single_cnt_r;
	logic                     prev_in_r;

	lcj_reading_t rdg  [2];
	lcj_stat_t    stat [2];
	assign rdg[0]  = res_rdg_in;
	assign rdg[1]  = volt_rdg_in;
	assign stat[0] = res_stat_in;
	assign stat[1] = volt_stat_in;

	wire        comp_en = ctrl_r[CTRL_COMP_EN];
	wire        method  = ctrl_r[CTRL_METHOD];
	wire        manual  = ctrl_r[CTRL_MANUAL];
	wire        abs_en  = ctrl_r[CTRL_ABS_EN];
	wire        cursor_numeric = ctrl_r[CTRL_CURSOR];
	wire lcj_beep_t beep_mode =
		lcj_beep_t'(ctrl_r[CTRL_BEEP_MSB:CTRL_BEEP_LSB]);

	wire ctrl_wr = reg_wr_in && (reg_addr_in == ADR_CTRL);
	wire mcfg_wr = reg_wr_in && (reg_addr_in == ADR_MCFG);
	// load keys only off the numeric cursor
	wire cmd_ok  = reg_wr_in && (reg_addr_in == ADR_CMD) && !comp_en
		&& !cursor_numeric;
	wire cmd_rdg  = cmd_ok && reg_wdata_in[CMD_LOAD_RDG];
	wire cmd_stat = cmd_ok && reg_wdata_in[CMD_LOAD_STAT] && stat_valid_in;
	wire cmd_low  = reg_wdata_in[CMD_LOWER];
	wire cmd_ch   = reg_wdata_in[CMD_CHAN];

	// only the enable bit moves while enabled
	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			ctrl_r <= CTRL_RESET;
		else if (ctrl_wr && comp_en)
			ctrl_r[CTRL_COMP_EN] <= reg_wdata_in[CTRL_COMP_EN];
		else if (ctrl_wr)
			ctrl_r <= reg_wdata_in[7:0];
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			mcfg_r <= MCFG_RESET;
		else if (ctrl_wr && !comp_en && reg_wdata_in[CTRL_COMP_EN])
			mcfg_r[MCFG_AUTORNG] <= 1'b0;
		else if (mcfg_wr && !comp_en)
			mcfg_r <= reg_wdata_in[MCFG_W-1:0];
	end

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		localparam logic [19:0] MAXV = (ch == 0) ? R_MAX : V_MAX;
		localparam logic [3:0]  BASE = (ch == 0) ? ADR_R_BASE : ADR_V_BASE;
		wire lcj_reading_t r = rdg[ch];
		wire [3:0] off  = reg_addr_in - BASE;
		wire       blk  = (reg_addr_in >= BASE) && (off < 4'h4);
		wire [19:0] wv  = reg_wdata_in[19:0];
		wire       wv_ok = (reg_wdata_in[DATA_W-1:20] == '0) && (wv <= MAXV);
		wire       tv_ok = (reg_wdata_in[DATA_W-1:20] == '0)
			&& (wv <= TOL_MAX);
		wire       wr_en = reg_wr_in && !comp_en && blk;
		wire       my_cmd = (cmd_ch == 1'(ch));

		wire [39:0] ref40 = {20'h0, ref_r[ch]};
		wire [39:0] up_calc = (ref40 * (PCT + {20'h0, tol_r[ch]})) / PCT;
		wire [39:0] lo_calc = (ref40 * (PCT - {20'h0, tol_r[ch]})) / PCT;
		wire [39:0] up_eff = method ? up_calc : {20'h0, up_r[ch]};
		wire [39:0] lo_eff = method ? lo_calc : {20'h0, lo_r[ch]};

		wire signed [21:0] diff = {r.value[20], r.value}
			- $signed({2'b00, ref_r[ch]});
		wire [21:0] adiff = diff[21] ? 22'(-diff) : diff;
		wire        ref0  = (ref_r[ch] == '0);
		wire [39:0] quot  = ref0 ? '0
			: ({18'h0, adiff} * PCT) / ref40;
		wire big   = ref0 ? (adiff != '0) : (quot > {20'h0, REL_LIM});
		wire rel_h = !diff[21] && big;
		wire rel_l = diff[21] && big;
		wire signed [20:0] rel_v = diff[21] ? -$signed({1'b0, quot[19:0]})
			: $signed({1'b0, quot[19:0]});

		wire        use_abs = (ch == 1) && abs_en;
		wire        neg  = r.value[20] && !use_abs;
		wire [20:0] umag = r.value[20] ? 21'(-r.value) : r.value;
		wire [39:0] mag  = {19'h0, umag};
		wire        ovh  = r.overflow_high || (method && rel_h);
		wire        ovl  = r.overflow_low || (method && rel_l);
		lcj_judge_t jdg_nxt;
		assign jdg_nxt = r.fault ? JDG_NONE
			: ovh ? JDG_HI
			: ovl ? JDG_LO
			: neg ? JDG_LO
			: (mag > up_eff) ? JDG_HI
			: (mag < lo_eff) ? JDG_LO
			: JDG_IN;

		wire rdg_ok = !r.fault && !r.overflow_high && !r.overflow_low
			&& !r.value[20] && (r.value[19:0] <= MAXV);

		always_ff @(posedge mclk_in) begin
			if (!rstn_in) begin
				judge_r[ch]   <= JDG_NONE;
				last_r[ch]    <= '0;
				last_ok_r[ch] <= 1'b0;
				rel_r[ch]     <= '0;
				relh_r[ch]    <= 1'b0;
				rell_r[ch]    <= 1'b0;
			end else if (r.done) begin
				judge_r[ch]   <= jdg_nxt;
				last_r[ch]    <= r.value[19:0];
				last_ok_r[ch] <= rdg_ok;
				rel_r[ch]     <= rel_v;
				relh_r[ch]    <= rel_h;
				rell_r[ch]    <= rel_l;
			end
		end

		wire [21:0] s3   = 22'(SIGMA_K * {2'b00, stat[ch].sigma});
		wire [21:0] m22  = {2'b00, stat[ch].mean};
		wire [21:0] sum  = m22 + s3;
		wire [19:0] st_up = (sum > {2'b00, MAXV}) ? MAXV : sum[19:0];
		wire [21:0] dif  = m22 - s3;
		wire [19:0] st_lo = (s3 > m22) ? '0
			: (dif > {2'b00, MAXV}) ? MAXV : dif[19:0];
		wire [19:0] st_rf = (stat[ch].mean > MAXV) ? MAXV : stat[ch].mean;
		wire [39:0] tq   = (stat[ch].mean == '0) ? {20'h0, TOL_MAX}
			: ({18'h0, s3} * PCT) / {20'h0, stat[ch].mean};
		wire [19:0] st_tl = (tq > {20'h0, TOL_MAX}) ? TOL_MAX : tq[19:0];

		wire ld_rdg = cmd_rdg && my_cmd && last_ok_r[ch];
		wire ld_st  = cmd_stat && my_cmd;

		// stored as counts, no range scaling
		always_ff @(posedge mclk_in) begin
			if (!rstn_in) begin
				up_r[ch]  <= '0;
				lo_r[ch]  <= '0;
				ref_r[ch] <= '0;
				tol_r[ch] <= '0;
			end else if (wr_en) begin
				if (off[1:0] == SLOT_UPPER && wv_ok)
					up_r[ch] <= wv;
				if (off[1:0] == SLOT_LOWER && wv_ok)
					lo_r[ch] <= wv;
				if (off[1:0] == SLOT_REF && wv_ok)
					ref_r[ch] <= wv;
				if (off[1:0] == SLOT_TOL && tv_ok)
					tol_r[ch] <= wv;
			end else if (ld_st) begin
				up_r[ch]  <= st_up;
				lo_r[ch]  <= st_lo;
				ref_r[ch] <= st_rf;
				tol_r[ch] <= st_tl;
			end else if (ld_rdg) begin
				if (method)
					ref_r[ch] <= last_r[ch];
				else if (cmd_low)
					lo_r[ch] <= last_r[ch];
				else
					up_r[ch] <= last_r[ch];
			end
		end
	end

	// manual mode needs the external gate
	wire gate_open = comp_en && (!manual || hand_judge_gate_in);
	wire both_in   = (judge_r[0] == JDG_IN) && (judge_r[1] == JDG_IN);
	wire have      = (judge_r[0] != JDG_NONE) && (judge_r[1] != JDG_NONE);
	wire any_jdg   = (judge_r[0] != JDG_NONE) || (judge_r[1] != JDG_NONE);
	wire out_band  = have && !both_in;

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			res_out_r  <= JDG_NONE;
			volt_out_r <= JDG_NONE;
			pass_r     <= 1'b0;
			fail_r     <= 1'b0;
		end else begin
			res_out_r  <= gate_open ? judge_r[0] : JDG_NONE;
			volt_out_r <= gate_open ? judge_r[1] : JDG_NONE;
			pass_r     <= gate_open && both_in;
			fail_r     <= gate_open && any_jdg && !both_in;
		end
	end

	// repeat tone; long period traded for a wide counter
	wire tone_wrap = (tone_cnt_r >= 32'(BEEP_CYCLES - 1));
	wire enter_in  = have && both_in && !prev_in_r;
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			tone_cnt_r   <= '0;
			tone_r       <= 1'b0;
			single_cnt_r <= '0;
			prev_in_r    <= 1'b0;
		end else begin
			tone_cnt_r <= tone_wrap ? '0 : tone_cnt_r + 32'h1;
			if (tone_wrap)
				tone_r <= !tone_r;
			prev_in_r <= have && both_in;
			if (enter_in)
				single_cnt_r <= 32'(BEEP_CYCLES);
			else if (single_cnt_r != '0)
				single_cnt_r <= single_cnt_r - 32'h1;
		end
	end

	logic beep_nxt;
	always_comb begin
		beep_nxt = 1'b0;
		case (beep_mode)
			BM_OFF:
				beep_nxt = 1'b0;
			BM_REPEAT_ON_OUT_OF_BAND:
				beep_nxt = out_band && tone_r;
			BM_STEADY_ON_PASS:
				beep_nxt = both_in;
			BM_STEADY_PASS_REPEAT_OUT:
				beep_nxt = both_in || (out_band && tone_r);
			BM_SINGLE_PASS_REPEAT_OUT:
				beep_nxt = (both_in && single_cnt_r != '0)
					|| (out_band && tone_r);
			default:
				beep_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			beep_r <= 1'b0;
		else
			beep_r <= comp_en && have && beep_nxt;
	end

	// register read, data valid the cycle after the strobe
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (reg_addr_in)
			ADR_CTRL:   rd_mux = {24'h0, ctrl_r};
			4'h1:       rd_mux = {12'h0, up_r[0]};
			4'h2:       rd_mux = {12'h0, lo_r[0]};
			4'h3:       rd_mux = {12'h0, ref_r[0]};
			4'h4:       rd_mux = {12'h0, tol_r[0]};
			4'h5:       rd_mux = {12'h0, up_r[1]};
			4'h6:       rd_mux = {12'h0, lo_r[1]};
			4'h7:       rd_mux = {12'h0, ref_r[1]};
			4'h8:       rd_mux = {12'h0, tol_r[1]};
			ADR_MCFG:   rd_mux = {16'h0, mcfg_r};
			ADR_STATUS: rd_mux = {24'h0, rell_r[1], rell_r[0], relh_r[1],
				relh_r[0], judge_r[1], judge_r[0]};
			ADR_R_REL:  rd_mux = 32'(rel_r[0]);
			ADR_V_REL:  rd_mux = 32'(rel_r[1]);
			default:    rd_mux = '0;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			rdata_r <= '0;
		else
			rdata_r <= reg_rd_in ? rd_mux : '0;
	end

	assign reg_rdata_out  = rdata_r;
	assign res_judge_out  = res_out_r;
	assign volt_judge_out = volt_out_r;
	assign pass_out       = pass_r;
	assign fail_out       = fail_r;
	assign beep_out       = beep_r;
	assign meas_cfg_out   = mcfg_r;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);

	AST_SETTINGS_LOCKED: assert property (
		comp_en && reg_wr_in && reg_addr_in == ADR_R_BASE |=>
		up_r[0] == $past(up_r[0]))
		else $error("threshold changed while comparator enabled");
	AST_BEEP_SILENT: assert property (
		(beep_mode == BM_OFF || !have) |=> !beep_out)
		else $error("beeper sounded when it must be silent");
	AST_MANUAL_GATE: assert property (
		manual && !hand_judge_gate_in |=>
		res_judge_out == JDG_NONE && !pass_out && !fail_out)
		else $error("result shown with manual gate closed");
	AST_AUTORANGE_OFF: assert property (
		$rose(comp_en) |-> !meas_cfg_out[MCFG_AUTORNG])
		else $error("auto-ranging still on after enable");
	AST_FAULT_NONE: assert property (
		res_rdg_in.done && res_rdg_in.fault |=> judge_r[0] == JDG_NONE)
		else $error("faulty reading produced a judgment");
	AST_OVF_HIGH: assert property (
		volt_rdg_in.done && !volt_rdg_in.fault
		&& volt_rdg_in.overflow_high |=> judge_r[1] == JDG_HI)
		else $error("positive overflow not judged Hi");
	AST_EQUAL_IN: assert property (
		res_rdg_in.done && !res_rdg_in.fault && !res_rdg_in.overflow_high
		&& !res_rdg_in.overflow_low && !method && lo_r[0] <= up_r[0]
		&& res_rdg_in.value == $signed({1'b0, up_r[0]})
		|=> judge_r[0] == JDG_IN)
		else $error("reading equal to upper limit not IN");
	AST_LIMIT_HELD: assert property (
		up_r[0] <= R_MAX && lo_r[0] <= R_MAX && tol_r[1] <= TOL_MAX)
		else $error("stored value beyond its limit");
	AST_PASS_BOTH: assert property (
		pass_out |-> $past(judge_r[0]) == JDG_IN
		&& $past(judge_r[1]) == JDG_IN && !fail_out)
		else $error("pass without both channels IN");
	AST_ABS_VOLT: assert property (
		volt_rdg_in.done && !abs_en && volt_rdg_in.value < 0
		&& !volt_rdg_in.fault && !volt_rdg_in.overflow_high && !method
		|=> judge_r[1] == JDG_LO)
		else $error("negative voltage not Lo without magnitude mode");

	COV_PASS:     cover property (pass_out ##1 fail_out);
	COV_SINGLE:   cover property (enter_in && beep_mode ==
		BM_SINGLE_PASS_REPEAT_OUT);
	COV_LOAD_ST:  cover property (cmd_stat);
	COV_MAN_GATE: cover property (manual && $rose(hand_judge_gate_in));

endmodule : lcj_judge

/* tb/lcj_front_model.sv */
`timescale 1ns/10ps
module lcj_front_model (
	// clock
	input  wire logic             mclk_in,
	// readings and statistics
	output lcj_pkg::lcj_reading_t res_rdg_out,
	output lcj_pkg::lcj_reading_t volt_rdg_out,
	output lcj_pkg::lcj_stat_t    res_stat_out,
	output lcj_pkg::lcj_stat_t    volt_stat_out,
	output logic                  stat_valid_out,
	// external control
	output logic                  hand_judge_gate_out
);
	import lcj_pkg::*;

	initial begin
		res_rdg_out = '0;
		volt_rdg_out = '0;
		res_stat_out = '0;
		volt_stat_out = '0;
		stat_valid_out = 1'b0;
		hand_judge_gate_out = 1'b0;
	end

	task automatic meas(input logic [20:0] rv, input logic [2:0] rf,
			input logic [20:0] vv, input logic [2:0] vf);
		res_rdg_out  <= {1'b1, rv, rf};
		volt_rdg_out <= {1'b1, vv, vf};
		@(posedge mclk_in);
		// fields mean nothing without done, so stop holding them
		res_rdg_out  <= {1'b0, ~rv, ~rf};
		volt_rdg_out <= {1'b0, ~vv, ~vf};
	endtask : meas

	task automatic stat(input logic [19:0] rm, input logic [19:0] rs,
			input logic [19:0] vm, input logic [19:0] vs, input logic ok);
		res_stat_out   <= {rm, rs};
		volt_stat_out  <= {vm, vs};
		stat_valid_out <= ok;
	endtask : stat

	task automatic gate(input logic g);
		hand_judge_gate_out <= g;
	endtask : gate
endmodule : lcj_front_model

/* tb/tb_limit_comparator_judge.sv */
`timescale 1ns/10ps
module tb_limit_comparator_judge;
	import lcj_pkg::*;

	// short beeper period keeps the run small
	localparam int BP = 8;
	localparam int PC = int'(PCT);
	localparam int RL = int'(REL_LIM);
	localparam int TH_UP = 32'sh3A98;
	localparam int TH_LO = 32'sh2710;

	logic              mclk_in = 1'b0;
	logic              rstn_in = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	lcj_reading_t      res_rdg;
	lcj_reading_t      volt_rdg;
	lcj_stat_t         res_stat;
	lcj_stat_t         volt_stat;
	logic              stat_valid;
	logic              hand_judge_gate;
	lcj_judge_t        res_judge;
	lcj_judge_t        volt_judge;
	logic              pass;
	logic              fail;
	logic              beep;
	logic [MCFG_W-1:0] meas_cfg;
	int                err_count = 0;
	int                checks = 0;
	int                seed = 32'h49E4EA95;
	int                r, v, f, n, up, lo;
	logic [2:0]        rf, vf;
	int                cr[5] = '{TH_LO, TH_UP, 32'sh270F, 32'sh3A99, 32'sh2EE0};
	int                cv[5] = '{TH_UP, TH_LO, 32'sh3A99, 32'sh270F, -32'sh2EE0};
	int                bm[9] = '{0, 1, 1, 3, 3, 2, 2, 2, 6};
	int                bh[9] = '{0, 0, 1, 0, 1, 0, 1, 0, 0};
	int                bk[9] = '{0, 0, 2, 1, 0, 1, 2, 0, 3};

	always #12.5 mclk_in = ~mclk_in;

	lcj_front_model u_lcj_front_model (
		.mclk_in(mclk_in), .res_rdg_out(res_rdg), .volt_rdg_out(volt_rdg),
		.res_stat_out(res_stat), .volt_stat_out(volt_stat),
		.stat_valid_out(stat_valid), .hand_judge_gate_out(hand_judge_gate)
	);

	lcj_judge #(
		.BEEP_CYCLES(BP)
	) u_lcj_judge (
		.mclk_in(mclk_in), .rstn_in(rstn_in),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
		.res_rdg_in(res_rdg), .volt_rdg_in(volt_rdg),
		.res_stat_in(res_stat), .volt_stat_in(volt_stat),
		.stat_valid_in(stat_valid), .hand_judge_gate_in(hand_judge_gate),
		.res_judge_out(res_judge), .volt_judge_out(volt_judge),
		.pass_out(pass), .fail_out(fail), .beep_out(beep),
		.meas_cfg_out(meas_cfg)
	);

	task automatic chk_v(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_v

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk_in);
		reg_wr <= 1'b0;
		@(posedge mclk_in);
	endtask : wr

	task automatic rdc(input logic [3:0] a, input logic [31:0] e,
			input string nm);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk_in);
		reg_rd <= 1'b0;
		#1;
		chk_v(nm, e, reg_rdata);
		@(posedge mclk_in);
	endtask : rdc

	function automatic lcj_judge_t ej(input int x0, input logic [2:0] fl,
			input int u, input int l, input bit ab);
		int x;
		x = (ab && x0 < 0) ? -x0 : x0;
		if (fl[2]) return JDG_NONE;
		if (fl[1]) return JDG_HI;
		if (fl[0] || x < 0 || x < l) return JDG_LO;
		if (x > u) return JDG_HI;
		return JDG_IN;
	endfunction : ej

	function automatic int lim(input int rv, input int t);
		return rv * (PC + t) / PC;
	endfunction : lim

	function automatic int rel(input int m, input int rv);
		return (m - rv) * PC / rv;
	endfunction : rel

	task automatic jud(input int rr, input logic [2:0] rfl, input int vv,
			input logic [2:0] vfl, input int u = TH_UP, input int l = TH_LO,
			input bit ab = 1'b0, input bit g = 1'b1);
		lcj_judge_t er;
		lcj_judge_t ev;
		logic       ep;
		logic       ef;
		er = g ? ej(rr, rfl, u, l, 1'b0) : JDG_NONE;
		ev = g ? ej(vv, vfl, u, l, ab) : JDG_NONE;
		ep = er == JDG_IN && ev == JDG_IN;
		ef = (er != JDG_NONE || ev != JDG_NONE) && !ep;
		u_lcj_front_model.meas(rr[20:0], rfl, vv[20:0], vfl);
		repeat (3) @(posedge mclk_in);
		#1;
		chk_v("res judge", {30'h0, er}, {30'h0, res_judge});
		chk_v("volt judge", {30'h0, ev}, {30'h0, volt_judge});
		chk_v("pass", {31'h0, ep}, {31'h0, pass});
		chk_v("fail", {31'h0, ef}, {31'h0, fail});
		@(posedge mclk_in);
	endtask : jud

	task automatic results();
		$display("comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results

	initial begin
		repeat (20000) @(posedge mclk_in);
		err_count++;
		results();
	end

	initial begin
		repeat (3) @(posedge mclk_in);
		#1;
		chk_v("cfg", {16'h0, MCFG_RESET}, {16'h0, meas_cfg});
		chk_v("beep", 32'h0, {31'h0, beep});
		@(posedge mclk_in);
		rstn_in <= 1'b1;
		@(posedge mclk_in);
		rdc(ADR_CTRL, 32'h0, "ctrl");
		u_lcj_front_model.meas(21'h3039, 3'b000, 21'h3E8, 3'b000);
		wr(ADR_CMD, 32'h1);
		rdc(ADR_R_BASE, 32'h3039, "load upper");
		wr(ADR_CMD, 32'h5);
		rdc(ADR_R_BASE + 4'h1, 32'h3039, "load lower");
		u_lcj_front_model.meas(21'h309, 3'b010, 21'h3E8, 3'b000);
		wr(ADR_CMD, 32'h1);
		rdc(ADR_R_BASE, 32'h3039, "load ovf");
		u_lcj_front_model.meas(21'h22B, 3'b000, 21'h3E8, 3'b000);
		wr(ADR_CTRL, 32'h80);
		wr(ADR_CMD, 32'h1);
		rdc(ADR_R_BASE, 32'h3039, "load cursor");
		wr(ADR_CTRL, 32'h0);
		u_lcj_front_model.stat(20'h3E8, 20'h64, 20'hF1B30, 20'h2710, 1'b0);
		wr(ADR_CMD, 32'h2);
		rdc(ADR_R_BASE, 32'h3039, "no stat");
		u_lcj_front_model.stat(20'h3E8, 20'h64, 20'hF1B30, 20'h2710, 1'b1);
		wr(ADR_CMD, 32'h2);
		rdc(ADR_R_BASE, 32'h3E8 + 32'h3 * 32'h64, "stat up");
		rdc(ADR_R_BASE + 4'h1, 32'h3E8 - 32'h3 * 32'h64, "stat lo");
		rdc(ADR_R_BASE + 4'h2, 32'h3E8, "stat ref");
		rdc(ADR_R_BASE + 4'h3, 32'h3 * 32'h64 * PC / 32'h3E8, "tol");
		wr(ADR_CMD, 32'hA);
		rdc(ADR_V_BASE, {12'h0, V_MAX}, "stat clamp");
		u_lcj_front_model.stat(20'h64, 20'h64, 20'hF1B30, 20'h2710, 1'b1);
		wr(ADR_CMD, 32'h2);
		rdc(ADR_R_BASE + 4'h1, 32'h0, "lo clamp");
		rdc(ADR_R_BASE + 4'h3, {12'h0, TOL_MAX}, "tol clamp");
		wr(ADR_R_BASE, TH_UP);
		wr(ADR_R_BASE + 4'h1, TH_LO);
		wr(ADR_V_BASE + 4'h1, TH_LO);
		rdc(ADR_R_BASE, TH_UP, "upper");
		wr(ADR_R_BASE, 32'h186A0);
		rdc(ADR_R_BASE, TH_UP, "upper limit");
		wr(ADR_V_BASE, {12'h0, V_MAX});
		rdc(ADR_V_BASE, {12'h0, V_MAX}, "volt max");
		wr(ADR_V_BASE, 32'hF4240);
		rdc(ADR_V_BASE, {12'h0, V_MAX}, "volt limit");
		wr(ADR_V_BASE, TH_UP);
		wr(ADR_R_BASE + 4'h3, 32'h1F4);
		wr(ADR_R_BASE + 4'h3, 32'h186A0);
		rdc(ADR_R_BASE + 4'h3, 32'h1F4, "tol limit");
		rdc(4'hE, 32'h0, "unmapped");
		wr(ADR_CTRL, 32'h1);
		rdc(ADR_MCFG, {16'h0, MCFG_RESET & 16'hFFFE}, "autorange");
		wr(ADR_MCFG, 32'hFFFF);
		rdc(ADR_MCFG, {16'h0, MCFG_RESET & 16'hFFFE}, "cfg lock");
		wr(ADR_R_BASE, 32'h2B67);
		rdc(ADR_R_BASE, TH_UP, "upper lock");
		wr(ADR_CTRL, 32'hB);
		rdc(ADR_CTRL, 32'h1, "ctrl lock");
		wr(ADR_CMD, 32'h2);
		rdc(ADR_R_BASE, TH_UP, "cmd lock");
		for (int p = 0; p < 2; p++) begin
			wr(ADR_CTRL, 32'h0);
			wr(ADR_CTRL, p ? 32'h9 : 32'h1);
			for (int i = 0; i < 24; i++) begin
				r = cr[i % 5];
				v = cv[i % 5];
				rf = 3'b000;
				vf = 3'b000;
				if (i >= 5) begin
					r = 32'sh1F40 + ($random(seed) & 32'sh1FFF);
					v = 32'sh1F40 + ($random(seed) & 32'sh1FFF);
					if ($random(seed) & 1) v = -v;
					f = $random(seed) & 7;
					rf = f < 3 ? 3'b100 >> f : 3'b000;
					f = $random(seed) & 7;
					vf = f < 3 ? 3'b100 >> f : 3'b000;
				end
				jud(r, rf, v, vf, TH_UP, TH_LO, p[0]);
			end
		end
		wr(ADR_CTRL, 32'h0);
		wr(ADR_CTRL, 32'h5);
		jud(32'sh2EE0, 3'b000, 32'sh2EE0, 3'b000, TH_UP, TH_LO, 1'b0, 1'b0);
		u_lcj_front_model.gate(1'b1);
		jud(32'sh2EE0, 3'b000, 32'sh2EE0, 3'b000);
		// single-beep case runs last, after a faulted reading left no judgment
		for (int i = 0; i < 9; i++) begin
			wr(ADR_CTRL, 32'h0);
			wr(ADR_CTRL, 32'h1 | (bm[i] << 4));
			u_lcj_front_model.meas(bh[i] ? 21'h3E80 : 21'h2EE0,
				i == 7 ? 3'b100 : 3'b000, 21'h2EE0, 3'b000);
			if (bm[i] != 6) repeat (4) @(posedge mclk_in);
			n = 0;
			repeat (4 * BP) begin
				#1;
				n += beep;
				@(posedge mclk_in);
			end
			f = bk[i] == 1 ? 4 * BP : bk[i] == 2 ? 2 * BP : bk[i] == 3 ? BP : 0;
			chk_v("beep", f, n);
		end
		wr(ADR_CTRL, 32'h0);
		wr(ADR_CTRL, 32'h2);
		// reference mode sends a reading load to the reference slot
		u_lcj_front_model.meas(21'h2EE0, 3'b000, 21'h3039, 3'b000);
		wr(ADR_CMD, 32'h9);
		rdc(ADR_V_BASE + 4'h2, 32'h3039, "load ref");
		wr(ADR_R_BASE + 4'h2, TH_LO);
		wr(ADR_R_BASE + 4'h3, 32'h1388);
		wr(ADR_V_BASE + 4'h2, TH_LO);
		wr(ADR_V_BASE + 4'h3, 32'h1388);
		wr(ADR_CTRL, 32'h3);
		up = lim(TH_LO, 32'sh1388);
		lo = lim(TH_LO, -32'sh1388);
		jud(32'sh2904, 3'b000, 32'sh251C, 3'b000, up, lo);
		rdc(ADR_R_REL, rel(32'sh2904, TH_LO), "res rel");
		rdc(ADR_V_REL, rel(32'sh251C, TH_LO), "volt rel");
		jud(32'sh2905, 3'b000, 32'sh251B, 3'b000, up, lo);
		jud(32'sh4E20, 3'b000, -32'sh1, 3'b000, up, lo);
		rdc(ADR_STATUS, {24'h0, rel(-32'sh1, TH_LO) < -RL, 2'b00,
			rel(32'sh4E20, TH_LO) > RL, JDG_LO, JDG_HI}, "status");
		results();
	end
endmodule : tb_limit_comparator_judge
